/* rtf_pkg.sv */
// Purpose: shared constants, types and states of the reader transmit framer
// Assumes: 200 MHz system clock
// Notes: command codes not fixed elsewhere are held here as named constants
package rtf_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 5;
  localparam int TARI_A_NS = 6250;
  localparam int TARI_B_NS = 12500;
  localparam int TARI_C_NS = 25000;
  localparam int DELIM_NS = 12500;
  localparam int TRCAL_UNIT_NS = 100;
  localparam int SLOT_UNIT_NS = 1000;
  localparam int TARI_A_CYC = TARI_A_NS / CLK_NS;
  localparam int TARI_B_CYC = TARI_B_NS / CLK_NS;
  localparam int DELIM_CYC = DELIM_NS / CLK_NS;
  localparam int TRCAL_UNIT_CYC = TRCAL_UNIT_NS / CLK_NS;
  localparam int SLOT_UNIT_CYC = SLOT_UNIT_NS / CLK_NS;
  // per-cent of tari, indexed by the select code
  localparam logic [7:0] PW_PCT [0:3] = '{8'h1B, 8'h23, 8'h2C, 8'h32};
  localparam logic [7:0] D1_PCT [0:3] = '{8'h96, 8'hA6, 8'hB7, 8'hC8};
  localparam logic [7:0] PCT_DIV = 8'h64;
  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam logic [7:0] A_PROTO = 8'h01;
  localparam logic [7:0] A_TXOPT = 8'h02;
  localparam logic [7:0] A_RXOPT = 8'h03;
  localparam logic [7:0] A_TRCAL_LO = 8'h04;
  localparam logic [7:0] A_TRCAL_HI = 8'h05;
  localparam logic [7:0] A_SLOT = 8'h06;
  localparam logic [7:0] A_IRQ = 8'h0C;
  localparam logic [7:0] A_LEN1 = 8'h1D;
  localparam logic [7:0] A_LEN2 = 8'h1E;
  localparam logic [7:0] A_FIFO = 8'h1F;
  localparam int IRQ_END_BIT = 7;
  localparam int IRQ_LOW_BIT = 6;
  localparam logic [7:0] PROTO_RST = 8'h02;
  localparam logic [7:0] TXOPT_RST = 8'hF0;
  localparam logic [7:0] RXOPT_RST = 8'h60;
  localparam logic [7:0] TRCAL_LO_RST = 8'h35;
  localparam logic [7:0] TRCAL_HI_RST = 8'h05;
  // ****************************************************************
  // commands (host write with address bit 7 set)
  // ****************************************************************
  localparam logic [7:0] C_TX_NOCRC = 8'h90;
  localparam logic [7:0] C_TX_CRC = 8'h91;
  localparam logic [7:0] C_DLY_NOCRC = 8'h92;
  localparam logic [7:0] C_DLY_CRC = 8'h93;
  localparam logic [7:0] C_QUERY = 8'h98;
  localparam logic [7:0] C_QREP = 8'h99;
  localparam logic [7:0] C_QADJ = 8'h9A;
  localparam logic [7:0] C_ACK = 8'h9B;
  localparam logic [7:0] C_NAK = 8'h9C;
  localparam logic [7:0] C_REQRN = 8'h9D;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC5_POLY = 16'h0009;
  localparam logic [15:0] CRC5_PRESET = 16'h0009;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } rtf_acc_s;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_CRC5 = 2'h1,
    K_CRC16 = 2'h2
  } rtf_crc_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WAITRX = 4'h1,
    S_TIMER = 4'h2,
    S_ARM = 4'h3,
    S_DELIM = 4'h4,
    S_DATA0 = 4'h5,
    S_RTCAL = 4'h6,
    S_TRCAL = 4'h7,
    S_BITS = 4'h8
  } rtf_state_e;
endpackage

/* rtf_tx_framer.sv */
// Purpose: normal-mode transmit framer and pulse coder of a UHF reader
// Assumes: host pins and host_clk are asynchronous; rx_done is on mclk
// Notes: mod_out high is carrier on, low is a modulated (low) interval
// How it works
// - host gives payload only; framing, CRC and pulse coding are done here.
// - a FIFO frame leaves the air interface only once a byte is queued.
// - a direct gen2 command starts sending at once, without FIFO data.
// - while sending, the FIFO falling to three bytes sets the low flag.
// - reading the cause register returns the cause and clears it.
// - the end of a transmission sets the end flag and raises irq.
// - byte count is first length register above nibble 7:4 of the second.
// - bit 0 flags a partial byte, bits 3:1 give its bit count.
// - delimiter, frame-sync or preamble and CRC are appended per protocol.
// - tari code 00 is 6.25 us, 01 is 12.5 us, others 25 us.
// - low pulse width is 0.27, 0.35, 0.44 or 0.5 tari.
// - data-1 length is 1.5, 1.66, 1.83 or 2 tari.
// - the session bits of transmit options go into query, query-rep and query-adjust.
// - a query carries a TRcal interval from the 12-bit TRcal value.
// - delayed commands arm a timer started by end of reception.
`timescale 1ns/1ps
module rtf_tx_framer
  import rtf_pkg::*;
#(
  parameter int FIFO_DEPTH = 24,
  parameter int LOW_MARK = 3,
  parameter int TARI_C_CYC = TARI_C_NS / CLK_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_clk,
  input wire logic host_sel,
  input wire logic host_we,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic rx_done,
  output logic [7:0] host_rdata,
  output logic irq,
  output logic mod_out,
  output logic tx_active
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PTRW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < LOW_MARK + 2 || FIFO_DEPTH > 31 || TARI_C_CYC < 8) begin : g_chk
    $error("rtf_tx_framer: parameter out of range");
  end

  // ****************************************************************
  // reset release and host pin synchronisers
  // ****************************************************************
  logic rst_q1;
  logic rst_sync_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  rtf_acc_s pin_q1;
  rtf_acc_s acc;
  logic hclk_q1, hclk_q2, hclk_q3, sel_q1, sel_q2;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_q1 <= '0;
      acc <= '0;
      hclk_q1 <= 1'b0;
      hclk_q2 <= 1'b0;
      hclk_q3 <= 1'b0;
      sel_q1 <= 1'b0;
      sel_q2 <= 1'b0;
    end else begin
      pin_q1 <= '{we: host_we, addr: host_addr, data: host_wdata};
      acc <= pin_q1;
      hclk_q1 <= host_clk;
      hclk_q2 <= hclk_q1;
      hclk_q3 <= hclk_q2;
      sel_q1 <= host_sel;
      sel_q2 <= sel_q1;
    end
  end

  // one access per rising host_clk edge while selected
  logic acc_go, cmd, wr, rd;
  assign acc_go = hclk_q2 && !hclk_q3 && sel_q2;
  assign cmd = acc_go && acc.we && acc.addr[7];
  assign wr = acc_go && acc.we && !acc.addr[7];
  assign rd = acc_go && !acc.we;

  // ****************************************************************
  // registers, FIFO and interrupt cause
  // ****************************************************************
  logic [7:0] proto_reg, txopt_reg, rxopt_reg, trl_reg, trh_reg, slot_reg;
  logic [7:0] len1_reg, len2_reg, cause_reg, rdata_reg, rn_hi_reg, rn_lo_reg;
  logic [7:0] proto_next, txopt_next, rxopt_next, trl_next, trh_next, slot_next;
  logic [7:0] len1_next, len2_next, cause_next, rdata_next, rn_hi_next, rn_lo_next;
  logic irq_reg, irq_next;
  logic [7:0] mem [0:FIFO_DEPTH-1];
  logic [PTRW-1:0] wp_reg, rp_reg, wp_next, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic push, pop, low_ev, tx_end_ev, act_reg;

  function automatic logic [PTRW-1:0] ptr_inc(input logic [PTRW-1:0] p);
    ptr_inc = (p == PTRW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push = wr && acc.addr == A_FIFO && cnt_reg != CW'(FIFO_DEPTH);
  assign low_ev = act_reg && pop && !push && cnt_reg == CW'(LOW_MARK + 1);

  always_comb begin
    proto_next = proto_reg;
    txopt_next = txopt_reg;
    rxopt_next = rxopt_reg;
    trl_next = trl_reg;
    trh_next = trh_reg;
    slot_next = slot_reg;
    len1_next = len1_reg;
    len2_next = len2_reg;
    rn_hi_next = rn_hi_reg;
    rn_lo_next = rn_lo_reg;
    rdata_next = rdata_reg;
    if (wr) begin
      case (acc.addr)
        A_PROTO: proto_next = acc.data;
        A_TXOPT: txopt_next = acc.data;
        A_RXOPT: rxopt_next = acc.data;
        A_TRCAL_LO: trl_next = acc.data;
        A_TRCAL_HI: trh_next = acc.data;
        A_SLOT: slot_next = acc.data;
        A_LEN1: len1_next = acc.data;
        A_LEN2: len2_next = acc.data;
        A_FIFO: begin
          // last two bytes written stand as the handle for ack and req_rn
          rn_hi_next = rn_lo_reg;
          rn_lo_next = acc.data;
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (acc.addr)
        A_PROTO: rdata_next = proto_reg;
        A_TXOPT: rdata_next = txopt_reg;
        A_RXOPT: rdata_next = rxopt_reg;
        A_TRCAL_LO: rdata_next = trl_reg;
        A_TRCAL_HI: rdata_next = trh_reg;
        A_SLOT: rdata_next = slot_reg;
        A_IRQ: rdata_next = cause_reg;
        A_LEN1: rdata_next = len1_reg;
        A_LEN2: rdata_next = len2_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    // read clears, a same-cycle event still lands
    cause_next = (rd && acc.addr == A_IRQ) ? 8'h00 : cause_reg;
    if (low_ev) begin
      cause_next[IRQ_LOW_BIT] = 1'b1;
    end
    if (tx_end_ev) begin
      cause_next[IRQ_END_BIT] = 1'b1;
    end
    irq_next = |cause_next;
    wp_next = push ? ptr_inc(wp_reg) : wp_reg;
    rp_next = pop ? ptr_inc(rp_reg) : rp_reg;
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      proto_reg <= PROTO_RST;
      txopt_reg <= TXOPT_RST;
      rxopt_reg <= RXOPT_RST;
      trl_reg <= TRCAL_LO_RST;
      trh_reg <= TRCAL_HI_RST;
      slot_reg <= 8'h00;
      len1_reg <= 8'h00;
      len2_reg <= 8'h00;
      rn_hi_reg <= 8'h00;
      rn_lo_reg <= 8'h00;
      cause_reg <= 8'h00;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      proto_reg <= proto_next;
      txopt_reg <= txopt_next;
      rxopt_reg <= rxopt_next;
      trl_reg <= trl_next;
      trh_reg <= trh_next;
      slot_reg <= slot_next;
      len1_reg <= len1_next;
      len2_reg <= len2_next;
      rn_hi_reg <= rn_hi_next;
      rn_lo_reg <= rn_lo_next;
      cause_reg <= cause_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_reg] <= acc.data;
    end
  end

  // ****************************************************************
  // symbol timing
  // ****************************************************************
  function automatic logic [19:0] frac(input logic [19:0] t, input logic [7:0] pc);
    logic [27:0] p;
    p = {8'h00, t} * {20'h00000, pc};
    frac = 20'(p / {20'h00000, PCT_DIV});
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                           input logic five);
    logic fb;
    fb = b ^ (five ? c[4] : c[15]);
    if (five) begin
      crc_step = {11'h000, c[3:0], 1'b0} ^ (fb ? CRC5_POLY : 16'h0000);
    end else begin
      crc_step = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
    end
  endfunction

  logic [19:0] tari_cyc, pw_cyc, d1_cyc, trcal_cyc;
  always_comb begin
    case (proto_reg[1:0])
      2'b00: tari_cyc = 20'(TARI_A_CYC);
      2'b01: tari_cyc = 20'(TARI_B_CYC);
      default: tari_cyc = 20'(TARI_C_CYC);
    endcase
    pw_cyc = frac(tari_cyc, PW_PCT[txopt_reg[7:6]]);
    d1_cyc = frac(tari_cyc, D1_PCT[txopt_reg[5:4]]);
    trcal_cyc = {8'h00, trh_reg[3:0], trl_reg} * 20'(TRCAL_UNIT_CYC);
  end

  // ****************************************************************
  // frame sequencer and bit serialiser
  // ****************************************************************
  rtf_state_e st_reg, st_next;
  rtf_crc_e kind_reg, kind_next;
  logic [19:0] cnt_sym_reg, cnt_sym_next, low_reg, low_next;
  logic [23:0] bsh_reg, bsh_next;
  logic [4:0] blen_reg, blen_next, take;
  logic [14:0] left_reg, left_next;
  logic [15:0] crc_reg, crc_next, tmr_reg, tmr_next;
  logic src_fifo_reg, src_fifo_next, pre_reg, pre_next;
  logic mod_reg, mod_next, act_next, go, sym_done;
  logic [1:0] sess;

  assign sess = txopt_reg[1:0];
  assign sym_done = cnt_sym_reg <= 20'd1;
  assign take = (left_reg >= 15'd8) ? 5'd8 : left_reg[4:0];

  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    bsh_next = bsh_reg;
    blen_next = blen_reg;
    left_next = left_reg;
    crc_next = crc_reg;
    tmr_next = tmr_reg;
    src_fifo_next = src_fifo_reg;
    pre_next = pre_reg;
    low_next = low_reg;
    cnt_sym_next = sym_done ? 20'd0 : cnt_sym_reg - 20'd1;
    pop = 1'b0;
    go = 1'b0;
    tx_end_ev = 1'b0;
    case (st_reg)
      S_IDLE: begin
        if (cmd) begin
          src_fifo_next = 1'b0;
          pre_next = 1'b0;
          left_next = '0;
          kind_next = K_NONE;
          go = 1'b1;
          case (acc.addr)
            C_TX_NOCRC, C_TX_CRC, C_DLY_NOCRC, C_DLY_CRC: begin
              go = 1'b0;
              src_fifo_next = 1'b1;
              blen_next = '0;
              kind_next = acc.addr[0] ? K_CRC16 : K_NONE;
              st_next = acc.addr[1] ? S_WAITRX : S_ARM;
            end
            C_QUERY: begin
              // dr, trext, sel, target and q are sent as zero
              bsh_next = {4'b1000, 1'b0, proto_reg[4:3], 3'b000, sess, 5'h00, 7'h00};
              blen_next = 5'd17;
              kind_next = K_CRC5;
              pre_next = 1'b1;
            end
            C_QREP: begin
              bsh_next = {2'b00, sess, 20'h00000};
              blen_next = 5'd4;
            end
            C_QADJ: begin
              bsh_next = {4'b1001, sess, 3'b000, 15'h0000};
              blen_next = 5'd9;
            end
            C_ACK: begin
              bsh_next = {2'b01, rn_hi_reg, rn_lo_reg, 6'h00};
              blen_next = 5'd18;
            end
            C_NAK: begin
              bsh_next = {8'hC0, 16'h0000};
              blen_next = 5'd8;
            end
            C_REQRN: begin
              bsh_next = {8'hC1, rn_hi_reg, rn_lo_reg};
              blen_next = 5'd24;
              kind_next = K_CRC16;
            end
            default: go = 1'b0;
          endcase
        end
      end
      S_WAITRX: begin
        if (rx_done) begin
          tmr_next = {8'h00, slot_reg} * 16'(SLOT_UNIT_CYC);
          st_next = S_TIMER;
        end
      end
      S_TIMER: begin
        if (tmr_reg == 16'h0000) begin
          st_next = S_ARM;
        end else begin
          tmr_next = tmr_reg - 16'h0001;
        end
      end
      S_ARM: begin
        // length follows the command, so it is taken only when the frame starts
        go = cnt_reg != '0;
        left_next = {len1_reg, len2_reg[7:4], 3'b000} +
                    (len2_reg[0] ? {12'h000, len2_reg[3:1]} : 15'h0000);
      end
      S_DELIM: begin
        if (sym_done) begin
          st_next = S_DATA0;
          cnt_sym_next = tari_cyc;
          low_next = pw_cyc;
        end
      end
      S_DATA0: begin
        if (sym_done) begin
          st_next = S_RTCAL;
          cnt_sym_next = tari_cyc + d1_cyc;
          low_next = pw_cyc;
        end
      end
      S_RTCAL: begin
        if (sym_done) begin
          st_next = pre_reg ? S_TRCAL : S_BITS;
          cnt_sym_next = pre_reg ? trcal_cyc : 20'd0;
        end
      end
      S_TRCAL: begin
        if (sym_done) begin
          st_next = S_BITS;
        end
      end
      S_BITS: begin
        if (sym_done) begin
          if (blen_reg != '0) begin
            cnt_sym_next = bsh_reg[23] ? d1_cyc : tari_cyc;
            low_next = pw_cyc;
            bsh_next = {bsh_reg[22:0], 1'b0};
            blen_next = blen_reg - 5'd1;
            if (kind_reg != K_NONE) begin
              crc_next = crc_step(crc_reg, bsh_reg[23], kind_reg == K_CRC5);
            end
          end else if (src_fifo_reg && left_reg != '0) begin
            // underrun stalls with carrier on rather than sending stale data
            if (cnt_reg != '0) begin
              pop = 1'b1;
              bsh_next = {mem[rp_reg], 16'h0000};
              blen_next = take;
              left_next = left_reg - {10'h000, take};
            end
          end else if (kind_reg == K_CRC16) begin
            bsh_next = {~crc_reg, 8'h00};
            blen_next = 5'd16;
            kind_next = K_NONE;
          end else if (kind_reg == K_CRC5) begin
            bsh_next = {crc_reg[4:0], 19'h00000};
            blen_next = 5'd5;
            kind_next = K_NONE;
          end else begin
            tx_end_ev = 1'b1;
            st_next = S_IDLE;
          end
        end
      end
      default: st_next = S_IDLE;
    endcase
    if (go) begin
      st_next = S_DELIM;
      cnt_sym_next = 20'(DELIM_CYC);
      low_next = 20'(DELIM_CYC);
      crc_next = (kind_next == K_CRC5) ? CRC5_PRESET : CRC16_PRESET;
    end
    mod_next = !(cnt_sym_next != 20'd0 && cnt_sym_next <= low_next);
    act_next = st_next >= S_DELIM;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= S_IDLE;
      kind_reg <= K_NONE;
      bsh_reg <= '0;
      blen_reg <= '0;
      left_reg <= '0;
      crc_reg <= CRC16_PRESET;
      tmr_reg <= '0;
      src_fifo_reg <= 1'b0;
      pre_reg <= 1'b0;
      cnt_sym_reg <= '0;
      low_reg <= '0;
      mod_reg <= 1'b1;
      act_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      bsh_reg <= bsh_next;
      blen_reg <= blen_next;
      left_reg <= left_next;
      crc_reg <= crc_next;
      tmr_reg <= tmr_next;
      src_fifo_reg <= src_fifo_next;
      pre_reg <= pre_next;
      cnt_sym_reg <= cnt_sym_next;
      low_reg <= low_next;
      mod_reg <= mod_next;
      act_reg <= act_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign irq = irq_reg;
  assign mod_out = mod_reg;
  assign tx_active = act_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_enter(rtf_state_e s);
    st_reg != s ##1 st_reg == s;
  endsequence
  sequence s_delayed_start;
    st_reg == S_WAITRX && rx_done ##1 st_reg == S_TIMER;
  endsequence

  property p_arm_wait;
    st_reg == S_ARM && cnt_reg == '0 |=> st_reg == S_ARM && mod_reg;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("frame left before data");
  property p_direct_go;
    st_reg == S_IDLE && cmd && acc.addr == C_QREP |=> st_reg == S_DELIM && !mod_reg;
  endproperty
  a_direct_go: assert property (p_direct_go) else $error("direct command late");
  property p_session;
    st_reg == S_IDLE && cmd && acc.addr == C_QREP |=> bsh_reg[21:20] == $past(sess);
  endproperty
  a_session: assert property (p_session) else $error("session bits not sent");
  property p_fifo_low;
    low_ev |=> cause_reg[IRQ_LOW_BIT] && irq;
  endproperty
  a_fifo_low: assert property (p_fifo_low) else $error("low level flag missing");
  property p_read_clear;
    rd && acc.addr == A_IRQ && !low_ev && !tx_end_ev |=>
      cause_reg == 8'h00 && host_rdata == $past(cause_reg);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("cause read wrong");
  property p_end_flag;
    st_reg == S_BITS && st_next == S_IDLE |=> cause_reg[IRQ_END_BIT] && !tx_active;
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag missing");
  property p_data0;
    s_enter(S_DATA0) |-> cnt_sym_reg == tari_cyc && low_reg == pw_cyc;
  endproperty
  a_data0: assert property (p_data0) else $error("tari or pulse width wrong");
  property p_rtcal;
    s_enter(S_RTCAL) |-> cnt_sym_reg == tari_cyc + d1_cyc;
  endproperty
  a_rtcal: assert property (p_rtcal) else $error("data-1 length wrong");
  property p_trcal;
    s_enter(S_TRCAL) |-> cnt_sym_reg == trcal_cyc && pre_reg;
  endproperty
  a_trcal: assert property (p_trcal) else $error("trcal interval wrong");
  property p_timer;
    s_delayed_start |-> tmr_reg == {8'h00, slot_reg} * 16'(SLOT_UNIT_CYC) && !tx_active;
  endproperty
  a_timer: assert property (p_timer) else $error("reply timer not loaded");
  property p_no_underrun;
    pop |-> cnt_reg != '0 && st_reg == S_BITS;
  endproperty
  a_no_underrun: assert property (p_no_underrun) else $error("read of empty fifo");
endmodule

/* rtf_host_model.sv */
// Purpose: host controller model on the framer's strobe and byte pins
// Assumes: 130 ns strobe period, pins set 60 ns before the strobe rises
// Notes: the strobe stands still between accesses
`timescale 1ns/1ps
module rtf_host_model (
  input wire logic mclk,
  output logic host_clk,
  output logic host_sel,
  output logic host_we,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  initial begin
    host_clk = 1'b0;
    host_sel = 1'b0;
    host_we = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
  end
  // ****************
  // one access
  // ****************
  task automatic access(input logic we, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd);
    @(posedge mclk);
    host_sel <= 1'b1;
    host_we <= we;
    host_addr <= a;
    host_wdata <= d;
    repeat (12) @(posedge mclk);
    host_clk <= 1'b1;
    repeat (13) @(posedge mclk);
    rd = host_rdata;
    host_clk <= 1'b0;
    host_sel <= 1'b0;
    // released bus shows the inverse so a stale value cannot pass
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask
endmodule

/* rtf_tx_framer_test.sv */
// Purpose: self-checking bench of the reader transmit framer
// Assumes: tari-c count cut to 16 cycles to keep frames short
// Notes: register accesses run from a row table, air cases by hand
`timescale 1ns/1ps
module rtf_tx_framer_test;
  import rtf_pkg::*;
  // ****************
  // bench state
  // ****************
  localparam int TC = 16;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } rtf_row_s;
  localparam rtf_row_s ROWS [0:14] = '{
    {1'b0, A_PROTO, 8'h00, 8'h02}, {1'b0, A_TXOPT, 8'h00, 8'hF0},
    {1'b0, A_RXOPT, 8'h00, 8'h60}, {1'b0, A_TRCAL_LO, 8'h00, 8'h35},
    {1'b0, A_TRCAL_HI, 8'h00, 8'h05}, {1'b0, A_SLOT, 8'h00, 8'h00},
    {1'b0, A_IRQ, 8'h00, 8'h00}, {1'b0, A_LEN1, 8'h00, 8'h00},
    {1'b0, A_LEN2, 8'h00, 8'h00}, {1'b0, A_FIFO, 8'h00, 8'h00},
    {1'b0, 8'h10, 8'h00, 8'h00}, {1'b1, A_TXOPT, 8'hA5, 8'h00},
    {1'b0, A_TXOPT, 8'h00, 8'hA5}, {1'b1, A_IRQ, 8'hFF, 8'h00},
    {1'b0, A_IRQ, 8'h00, 8'h00}};
  localparam int PW [0:3] = '{27, 35, 44, 50};
  localparam logic [7:0] CMDS [0:5] = '{C_QUERY, C_QREP, C_QADJ, C_ACK, C_NAK, C_REQRN};
  logic mclk, rst_n, rx_done, host_clk, host_sel, host_we, irq, mod_out, tx_active;
  logic [7:0] host_addr, host_wdata, host_rdata, rd;
  int fails, n_tests, low_n, last_low;
  rtf_tx_framer #(.TARI_C_CYC(TC)) rtf_tx_framer_i (.mclk(mclk), .rst_n(rst_n),
    .host_clk(host_clk), .host_sel(host_sel), .host_we(host_we), .host_addr(host_addr),
    .host_wdata(host_wdata), .rx_done(rx_done), .host_rdata(host_rdata), .irq(irq),
    .mod_out(mod_out), .tx_active(tx_active));
  rtf_host_model rtf_host_model_i (.mclk(mclk), .host_clk(host_clk), .host_sel(host_sel),
    .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // length of the last low interval on the air output
  initial begin
    low_n = 0;
    last_low = 0;
  end
  always @(posedge mclk) begin
    if (mod_out === 1'b0) begin
      low_n <= low_n + 1;
    end else if (low_n != 0) begin
      last_low <= low_n;
      low_n <= 0;
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    rtf_host_model_i.access(we, a, d, rd);
  endtask
  task automatic wait_mod(input logic v);
    for (int k = 0; k < 4000 && mod_out !== v; k++) @(posedge mclk);
  endtask
  task automatic end_frame(input logic [7:0] cause);
    for (int k = 0; k < 20000 && tx_active !== 1'b0; k++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    check(irq, 1'b1);
    acc(1'b0, A_IRQ, 8'h00);
    check(rd, cause);
    check(irq, 1'b0);
    $display("frame test done");
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    rx_done = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (ROWS[i]) begin
      acc(ROWS[i].we, ROWS[i].addr, ROWS[i].data);
      if (!ROWS[i].we) check(rd, ROWS[i].exp);
    end
    $display("register test done");
    // partial count set without its flag must be ignored
    acc(1'b1, C_TX_NOCRC, 8'h00);
    acc(1'b1, A_LEN1, 8'h00);
    acc(1'b1, A_LEN2, 8'h5E);
    repeat (50) @(posedge mclk);
    check(tx_active, 1'b0);
    for (int i = 0; i < 5; i++) acc(1'b1, A_FIFO, 8'hA0 + 8'(i));
    end_frame(8'hC0);
    acc(1'b1, A_SLOT, 8'h02);
    acc(1'b1, C_DLY_NOCRC, 8'h00);
    acc(1'b1, A_LEN2, 8'h10);
    acc(1'b1, A_FIFO, 8'h5A);
    repeat (20) @(posedge mclk);
    check(tx_active, 1'b0);
    rx_done <= 1'b1;
    @(posedge mclk);
    rx_done <= 1'b0;
    repeat (300) @(posedge mclk);
    check(tx_active, 1'b0);
    repeat (200) @(posedge mclk);
    check(tx_active, 1'b1);
    end_frame(8'h80);
    acc(1'b1, A_TRCAL_LO, 8'h10);
    acc(1'b1, A_TRCAL_HI, 8'h00);
    foreach (CMDS[i]) begin
      acc(1'b1, A_TXOPT, {i[1:0], 4'h3, ~i[1:0]});
      acc(1'b1, CMDS[i], 8'h00);
      check(tx_active, 1'b1);
      wait_mod(1'b1);
      wait_mod(1'b0);
      check(last_low, DELIM_CYC);
      wait_mod(1'b1);
      repeat (2) @(posedge mclk);
      check(last_low, TC * PW[i % 4] / 100);
      end_frame(8'h80);
    end
    // reset in mid-frame: outputs fall back to idle at once
    acc(1'b1, C_QREP, 8'h00);
    check(tx_active, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check(tx_active, 1'b0);
    check(mod_out, 1'b1);
    check(irq, 1'b0);
    check(host_rdata, 8'h00);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(1'b0, A_PROTO, 8'h00);
    check(rd, PROTO_RST);
    $display("reset test done");
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    finish_test();
  end
endmodule
